// ==== src/buffer_channel_activation.v ====
// sense/select sequence, channel activation, ready logic and scanner
// How it works
// - code to all, strobe to named channel
// - top three code bits name channel
// - lower second rank always drives lines
// - sense flop starts counter, strobe later
// - strobe held, then sequence resumes
// - low bit xor response picks exit
// - combined result resynchronized before use
// - upper position: full skips lower
// - lower position: half repeats sense
// - select: load, count, strobe, exit
// - activate loads channel, address, busy
// - wait while auxiliary operation busy
// - fast sequence writes ones, then address
// - copy pair to shared, set active
// - active channels run without program control
// - odd resync pulse raises service request
// - six channel scan, one flop changes
// - second rank moves only without request
// - stage one toggles, two, three follow
// - stages equal: grant, load designator
`timescale 1ns/1ps
`include "buffer_channel_defines.vh"
module buffer_channel_activation (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // external function lines
  output reg  [11:0] external_function_code,
  output reg  [5:0]  sense_strobe,
  output reg  [5:0]  function_strobe,
  input  wire        sense_response_input,
  // channel handshake
  output reg  [5:0]  channel_active,
  input  wire [5:0]  input_ready,
  input  wire [5:0]  output_resume,
  // auxiliary sequence side
  input  wire        aux_busy,
  input  wire        aux_release,
  output reg         storage_busy,
  output reg         grant_request,
  output reg  [2:0]  granted_channel_designator,
  output reg  [5:0]  granted_decode
);

  // ------------------------------------------------------------
  // states and constants
  // ------------------------------------------------------------
  localparam [3:0] ST_IDLE   = 4'h0;
  localparam [3:0] ST_LOAD   = 4'h1;
  localparam [3:0] ST_COUNT  = 4'h2;
  localparam [3:0] ST_RESYNC = 4'h3;
  localparam [3:0] ST_EXIT   = 4'h4;
  localparam [3:0] ST_ACT    = 4'h5;
  localparam [3:0] ST_HSS1   = 4'h6;
  localparam [3:0] ST_HSS2   = 4'h7;
  localparam [3:0] ST_HSS3   = 4'h8;
  localparam [3:0] ST_HSS4   = 4'h9;
  localparam [3:0] ST_HSS5   = 4'ha;
  localparam integer START_INT = `EXF_START_CYC;
  localparam integer END_INT   = `EXF_START_CYC + `EXF_HOLD_CYC;
  localparam [10:0]  START_CYC = START_INT[10:0];
  localparam [10:0]  END_CYC   = END_INT[10:0];

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  reg  [1:0]  phase_r;
  wire        odd_resync_pulse;
  wire        even_phase;
  reg  [3:0]  state_r;
  reg  [10:0] cnt_r;
  reg  [2:0]  op_r;
  reg         upper_r;
  reg  [14:0] addr_r;
  reg  [23:0] x2_lower_r;
  reg  [14:0] x2_upper_r;
  reg  [2:0]  channel_number_holding_reg;
  reg         sense_flop;
  reg         select_flop;
  reg         exit_flop;
  reg         combined_r;
  reg         resync_r;
  reg         exit_full_r;
  reg         skip_lower_r;
  reg         activate_instruction_flop;
  reg  [29:0] shared_update_register;
  reg  [5:0]  service_request_flop;
  reg  [5:0]  resume_seen_flop;
  reg  [5:0]  awaiting_resume_flop;
  reg  [2:0]  rank1_r;
  reg  [2:0]  rank2_r;
  reg         scanner_stage_one;
  reg         scanner_stage_two;
  reg         scanner_stage_three;
  reg         wr_upper;
  reg         wr_lower;
  reg  [2:0]  wr_idx;
  reg  [14:0] wr_data;
  reg  [5:0]  strobe_sel;
  reg  [2:0]  gray_next;
  wire [29:0] pair_rdata;
  wire        combined_sense_result;
  wire        cur_request;
  wire        advance_pulse_set;
  wire        advance_pulse_clear;
  wire        cmd_wr;
  wire [2:0]  exf_ch;

  // ------------------------------------------------------------
  // phase divider
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end
  assign odd_resync_pulse = (phase_r == `PHASE_ODD);
  assign even_phase       = (phase_r == `PHASE_EVEN);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  assign cmd_wr = reg_wr && (reg_addr == `OFF_CMD) && (state_r == ST_IDLE);
  assign exf_ch = x2_lower_r[`EXF_CH_MSB:`EXF_CH_LSB];
  assign combined_sense_result = x2_lower_r[0] ^ sense_response_input;

  always @* begin
    strobe_sel = 6'h0;
    if (exf_ch >= 3'h1 && exf_ch <= 3'h6) begin
      strobe_sel[exf_ch - 3'h1] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // external function and activation sequence
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r                    <= ST_IDLE;
      cnt_r                      <= 11'h0;
      op_r                       <= 3'h0;
      upper_r                    <= 1'b0;
      addr_r                     <= 15'h0;
      x2_lower_r                 <= 24'h0;
      x2_upper_r                 <= 15'h0;
      channel_number_holding_reg <= 3'h0;
      sense_flop                 <= 1'b0;
      select_flop                <= 1'b0;
      exit_flop                  <= 1'b0;
      combined_r                 <= 1'b0;
      resync_r                   <= 1'b0;
      exit_full_r                <= 1'b0;
      skip_lower_r               <= 1'b0;
      activate_instruction_flop  <= 1'b0;
      storage_busy               <= 1'b0;
      sense_strobe               <= 6'h0;
      function_strobe            <= 6'h0;
      shared_update_register     <= 30'h0;
      channel_active             <= 6'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          exit_flop <= 1'b0;
          if (cmd_wr) begin
            op_r    <= reg_wdata[`CMD_OP_MSB:`CMD_OP_LSB];
            upper_r <= reg_wdata[`CMD_UPPER_BIT];
            addr_r  <= reg_wdata[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (op_r == `OP_SENSE || op_r == `OP_SELECT) begin
            x2_lower_r  <= {{9{addr_r[14]}}, addr_r};
            sense_flop  <= (op_r == `OP_SENSE);
            select_flop <= (op_r == `OP_SELECT);
            if (op_r == `OP_SELECT && !exit_flop) begin
              resync_r <= 1'b1;
            end
            cnt_r   <= 11'h0;
            state_r <= ST_COUNT;
          end else begin
            channel_number_holding_reg <= op_r;
            x2_upper_r                 <= addr_r;
            state_r                    <= ST_ACT;
          end
        end
        ST_COUNT: begin
          cnt_r <= cnt_r + 11'h1;
          if (cnt_r == START_CYC - 11'h1) begin
            sense_strobe    <= sense_flop ? strobe_sel : 6'h0;
            function_strobe <= select_flop ? strobe_sel : 6'h0;
          end
          if (cnt_r == END_CYC - 11'h1) begin
            sense_strobe    <= 6'h0;
            function_strobe <= 6'h0;
            combined_r      <= combined_sense_result;
            state_r         <= sense_flop ? ST_RESYNC : ST_EXIT;
          end
        end
        ST_RESYNC: begin
          if (odd_resync_pulse) begin
            resync_r <= combined_r;
            state_r  <= ST_EXIT;
          end
        end
        ST_EXIT: begin
          exit_full_r  <= resync_r;
          skip_lower_r <= upper_r && resync_r;
          sense_flop   <= 1'b0;
          select_flop  <= 1'b0;
          resync_r     <= 1'b0;
          if (sense_flop && !upper_r && !resync_r) begin
            state_r <= ST_LOAD;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_ACT: begin
          storage_busy <= 1'b1;
          if (!aux_busy && !grant_request) begin
            activate_instruction_flop <= 1'b1;
            state_r                   <= ST_HSS1;
          end
        end
        ST_HSS1: begin
          storage_busy <= 1'b1;
          state_r      <= ST_HSS2;
        end
        ST_HSS2: begin
          state_r <= ST_HSS3;
        end
        ST_HSS3: begin
          shared_update_register <= 30'h0;
          state_r                <= ST_HSS4;
        end
        ST_HSS4: begin
          state_r <= ST_HSS5;
        end
        ST_HSS5: begin
          shared_update_register <= pair_rdata;
          channel_active[channel_number_holding_reg - 3'h1] <= 1'b1;
          activate_instruction_flop <= 1'b0;
          storage_busy              <= 1'b0;
          state_r                   <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // pair store port
  // ------------------------------------------------------------
  always @* begin
    wr_upper = 1'b0;
    wr_lower = 1'b0;
    wr_idx   = channel_number_holding_reg;
    wr_data  = x2_upper_r;
    if (state_r == ST_HSS1) begin
      wr_upper = 1'b1;
      wr_data  = `ADDR_ONES;
    end else if (state_r == ST_HSS2) begin
      wr_upper = 1'b1;
    end else if (reg_wr && reg_addr == `OFF_TERM) begin
      wr_lower = 1'b1;
      wr_idx   = reg_wdata[`TERM_CH_MSB:`TERM_CH_LSB];
      wr_data  = reg_wdata[`TERM_ADDR_MSB:0];
    end
  end

  address_pair_store u_pairs (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_upper(wr_upper),
    .wr_lower(wr_lower),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .rd_idx  (channel_number_holding_reg),
    .rd_data (pair_rdata)
  );

  // ------------------------------------------------------------
  // ready and resume logic per channel
  // ------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 6; c = c + 1) begin : chan
      wire served = aux_release && grant_request && (granted_channel_designator == c + 1);
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          service_request_flop[c] <= 1'b0;
          resume_seen_flop[c]     <= 1'b0;
          awaiting_resume_flop[c] <= 1'b0;
        end else if (!channel_active[c]) begin
          service_request_flop[c] <= 1'b0;
          resume_seen_flop[c]     <= 1'b0;
          awaiting_resume_flop[c] <= 1'b0;
        end else if (served) begin
          service_request_flop[c] <= (c % 2 == 0) && odd_resync_pulse && input_ready[c];
          awaiting_resume_flop[c] <= (c % 2 == 1);
        end else if (c % 2 == 1) begin
          if (awaiting_resume_flop[c] && output_resume[c]) begin
            resume_seen_flop[c]     <= 1'b1;
            awaiting_resume_flop[c] <= 1'b0;
          end else if (resume_seen_flop[c] && !output_resume[c]) begin
            resume_seen_flop[c] <= 1'b0;
          end else if (odd_resync_pulse && !awaiting_resume_flop[c] &&
                       !resume_seen_flop[c]) begin
            service_request_flop[c] <= 1'b1;
          end
        end else if (odd_resync_pulse && input_ready[c]) begin
          service_request_flop[c] <= 1'b1;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // auxiliary scanner
  // ------------------------------------------------------------
  assign cur_request = service_request_flop[rank1_r - 3'h1];
  assign advance_pulse_set   = odd_resync_pulse && !cur_request && !grant_request &&
                               !scanner_stage_one;
  assign advance_pulse_clear = odd_resync_pulse && !cur_request && !grant_request &&
                               scanner_stage_one;

  always @* begin
    case (rank1_r)
      3'h1: gray_next = 3'h3;
      3'h3: gray_next = 3'h2;
      3'h2: gray_next = 3'h6;
      3'h6: gray_next = 3'h4;
      3'h4: gray_next = 3'h5;
      3'h5: gray_next = 3'h1;
      default: gray_next = `SCAN_RESET;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rank1_r                    <= `SCAN_RESET;
      rank2_r                    <= `SCAN_RESET;
      scanner_stage_one          <= 1'b0;
      scanner_stage_two          <= 1'b0;
      scanner_stage_three        <= 1'b1;
      grant_request              <= 1'b0;
      granted_channel_designator <= 3'h0;
      granted_decode             <= 6'h0;
    end else begin
      if (advance_pulse_set) begin
        scanner_stage_one <= 1'b1;
      end else if (advance_pulse_clear) begin
        scanner_stage_one <= 1'b0;
      end
      if (even_phase) begin
        scanner_stage_two <= scanner_stage_one;
        if (!cur_request && !grant_request) begin
          rank2_r <= gray_next;
        end
      end
      if (odd_resync_pulse) begin
        scanner_stage_three <= scanner_stage_two;
        if (!cur_request && !grant_request) begin
          rank1_r <= rank2_r;
        end
      end
      if (grant_request) begin
        if (aux_release) begin
          grant_request  <= 1'b0;
          granted_decode <= 6'h0;
        end
      end else if (cur_request && scanner_stage_one == scanner_stage_three) begin
        grant_request              <= 1'b1;
        granted_channel_designator <= rank1_r;
        granted_decode             <= 6'h1 << (rank1_r - 3'h1);
      end
    end
  end

  // ------------------------------------------------------------
  // outputs from registers and read port
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      external_function_code <= 12'h0;
      reg_rdata              <= 32'h0;
    end else begin
      external_function_code <= {x2_lower_r[11:1], 1'b0};
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          `OFF_STATUS: reg_rdata <= {6'h0, granted_channel_designator, grant_request,
                                     service_request_flop, channel_active,
                                     1'b0, storage_busy, activate_instruction_flop,
                                     skip_lower_r, exit_full_r, (state_r != ST_IDLE),
                                     state_r};
          `OFF_SHARED: reg_rdata <= {2'h0, shared_update_register};
          default:     reg_rdata <= 32'h0;
        endcase
      end
    end
  end

endmodule

// ==== src/buffer_channel_defines.vh ====
// constants for buffer channel set-up, scanner and sense/select timing
`ifndef BUFFER_CHANNEL_DEFINES_VH
`define BUFFER_CHANNEL_DEFINES_VH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define EXF_START_NS      1600
`define EXF_HOLD_NS       12800
`define EXF_START_CYC     ((`EXF_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXF_HOLD_CYC      ((`EXF_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PHASE_ODD         2'h0
`define PHASE_EVEN        2'h2

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFF_CMD           4'h0
`define OFF_TERM          4'h1
`define OFF_STATUS        4'h2
`define OFF_SHARED        4'h3

// ------------------------------------------------------------
// command word fields
// ------------------------------------------------------------
`define CMD_OP_LSB        0
`define CMD_OP_MSB        2
`define CMD_UPPER_BIT     3
`define CMD_ADDR_LSB      4
`define CMD_ADDR_MSB      18
`define OP_SELECT         3'h0
`define OP_SENSE          3'h7

// ------------------------------------------------------------
// terminal write fields
// ------------------------------------------------------------
`define TERM_ADDR_MSB     14
`define TERM_CH_LSB       15
`define TERM_CH_MSB       17

// ------------------------------------------------------------
// code fields and reset values
// ------------------------------------------------------------
`define EXF_CH_LSB        9
`define EXF_CH_MSB        11
`define SCAN_RESET        3'h1
`define ADDR_ONES         15'h7fff

`endif

// ==== src/address_pair_store.v ====
// six-entry store of current and terminal address pairs
`timescale 1ns/1ps
module address_pair_store (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // write port
  input  wire        wr_upper,
  input  wire        wr_lower,
  input  wire [2:0]  wr_idx,
  input  wire [14:0] wr_data,
  // read port
  input  wire [2:0]  rd_idx,
  output reg  [29:0] rd_data
);

  wire [29:0] words [0:5];

  // ------------------------------------------------------------
  // per entry storage
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : entry
      reg [29:0] word_r;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          word_r <= 30'h0;
        end else if (wr_idx == g + 1) begin
          if (wr_upper) begin
            word_r[29:15] <= wr_data;
          end
          if (wr_lower) begin
            word_r[14:0] <= wr_data;
          end
        end
      end
      assign words[g] = word_r;
    end
  endgenerate

  // ------------------------------------------------------------
  // registered read
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 30'h0;
    end else if (rd_idx >= 3'h1 && rd_idx <= 3'h6) begin
      rd_data <= words[rd_idx - 3'h1];
    end else begin
      rd_data <= 30'h0;
    end
  end

endmodule

// ==== test/channel_checker.sv ====
// assertions on the buffer channel activation ports
`timescale 1ns/1ps
module channel_checker (
  // clock and reset
  input logic        clk,
  input logic        rst_n,
  // register writes
  input logic [3:0]  reg_addr,
  input logic [31:0] reg_wdata,
  input logic        reg_wr,
  // device outputs and auxiliary busy
  input logic [11:0] external_function_code,
  input logic [5:0]  sense_strobe,
  input logic [5:0]  function_strobe,
  input logic [5:0]  channel_active,
  input logic        aux_busy,
  input logic        storage_busy,
  input logic        grant_request,
  input logic [2:0]  granted_channel_designator,
  input logic [5:0]  granted_decode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----
  // strobe length counter
  // ----
  logic [11:0] hold_r;
  logic        any_s;
  logic        on_s;
  assign any_s = |sense_strobe;
  assign on_s  = any_s | (|function_strobe);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) hold_r <= 12'h000;
    else hold_r <= on_s ? hold_r + 12'h001 : 12'h000;
  end
  sequence sense_cmd_s;
    reg_wr && reg_addr == 4'h0 && reg_wdata[2:0] == 3'h7 && reg_wdata[15:13] != 3'h0
      && reg_wdata[15:13] != 3'h7 && !storage_busy && !on_s;
  endsequence
  sequence strobe_up_s;
    ##[160:164] $rose(any_s);
  endsequence
  strobe_one_hot_a: assert property ($onehot0(sense_strobe))
    else $error("more than one sense strobe");
  strobe_channel_a: assert property (any_s |->
    sense_strobe == 6'h01 << (external_function_code[11:9] - 3'h1))
    else $error("sense strobe on wrong channel");
  low_bit_a: assert property (!external_function_code[0])
    else $error("lowest code bit sent");
  code_stable_a: assert property (on_s |-> $stable(external_function_code))
    else $error("code moved under strobe");
  start_delay_a: assert property (sense_cmd_s |-> strobe_up_s)
    else $error("sense strobe late or early");
  strobe_hold_a: assert property ($fell(on_s) |-> hold_r == 12'd1280)
    else $error("strobe length wrong");
  grant_decode_a: assert property ($rose(grant_request) |->
    granted_decode == 6'h01 << (granted_channel_designator - 3'h1))
    else $error("decode does not match designator");
  first_request_a: assert property ($rose(|(channel_active & 6'h2a)) && !grant_request |->
    ##[1:200] grant_request)
    else $error("no grant after activation");
  aux_wait_a: assert property (storage_busy && aux_busy |=> $stable(channel_active))
    else $error("activation ran over auxiliary");
  active_sticky_a: assert property (($past(channel_active) & ~channel_active) == 6'h00)
    else $error("active channel dropped");
  busy_end_a: assert property ($fell(storage_busy) |-> $changed(channel_active))
    else $error("busy cleared without activation");
endmodule

// ==== test/periph_model.sv ====
// peripheral equipment on the buffer channel cables
`timescale 1ns/1ps
module periph_model (
  // clock and reset
  input  logic        clk,
  input  logic        rst_n,
  // lines from the device and auxiliary release
  input  logic [11:0] external_function_code,
  input  logic [5:0]  sense_strobe,
  input  logic [5:0]  function_strobe,
  input  logic        aux_release,
  input  logic [2:0]  granted_channel_designator,
  // condition per channel
  input  logic [5:0]  cond,
  // lines to the device
  output logic        sense_response_input,
  output logic [5:0]  output_resume
);
  logic [7:0] sel_unit_r [6];
  logic [3:0] hold_r;
  logic [2:0] ch;
  assign ch = external_function_code[11:9];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_response_input <= 1'b0;
      output_resume <= 6'h00;
      hold_r <= 4'h0;
    end else begin
      // answer only when addressed, else the released line wanders
      if (|sense_strobe) sense_response_input <= cond[ch - 3'h1];
      else sense_response_input <= ~sense_response_input;
      // new unit on a channel replaces the old one
      if (|function_strobe) sel_unit_r[ch - 3'h1] <= external_function_code[8:1];
      // output unit takes the word, resumes, then drops resume
      if (aux_release && !granted_channel_designator[0]) begin
        output_resume[granted_channel_designator - 3'h1] <= 1'b1;
        hold_r <= 4'h8;
      end else if (hold_r != 4'h0) begin
        hold_r <= hold_r - 4'h1;
        if (hold_r == 4'h1) output_resume <= 6'h00;
      end
    end
  end
endmodule

// ==== test/buffer_channel_activation_bench.sv ====
// self-checking bench for buffer channel activation
`timescale 1ns/1ps
module buffer_channel_activation_bench;
  logic        clk, rst_n, reg_wr, reg_rd, sense_response_input, aux_busy, aux_release;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, st;
  logic [11:0] external_function_code;
  logic [5:0]  sense_strobe, function_strobe, channel_active, input_ready, output_resume;
  logic [5:0]  cond, granted_decode;
  logic        storage_busy, grant_request;
  logic [2:0]  granted_channel_designator;
  logic [7:0]  rows [6] = '{8'h2f, 8'h5c, 8'h64, 8'h97, 8'ha9, 8'hd1};
  int          n_errors = 0, total_checks = 0, i;
  buffer_channel_activation buffer_channel_activation_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_function_code(external_function_code),
    .sense_strobe(sense_strobe), .function_strobe(function_strobe),
    .sense_response_input(sense_response_input), .channel_active(channel_active),
    .input_ready(input_ready), .output_resume(output_resume), .aux_busy(aux_busy),
    .aux_release(aux_release), .storage_busy(storage_busy), .grant_request(grant_request),
    .granted_channel_designator(granted_channel_designator), .granted_decode(granted_decode));
  periph_model periph_model_inst (
    .clk(clk), .rst_n(rst_n), .external_function_code(external_function_code),
    .sense_strobe(sense_strobe), .function_strobe(function_strobe), .aux_release(aux_release),
    .granted_channel_designator(granted_channel_designator), .cond(cond),
    .sense_response_input(sense_response_input), .output_resume(output_resume));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    st = reg_rdata;
  endtask
  task wait_idle;
    for (i = 0; i < 2000; i++) begin
      rd(4'h2);
      if (st[4] === 1'b0) break;
    end
    if (i == 2000) begin
      n_errors++;
      $display("mismatch at %0t: sequence stayed busy", $time);
    end
  endtask
  task wait_on(input int which, input int lim);
    for (i = 0; i < lim; i++) begin
      @(negedge clk);
      if (which == 0 && |sense_strobe) break;
      if (which == 1 && !(|sense_strobe)) break;
      if (which == 2 && |function_strobe) break;
      if (which == 3 && grant_request) break;
    end
    if (i == lim) begin
      n_errors++;
      $display("mismatch at %0t: wait %0d ran out", $time, which);
    end
  endtask
  task results;
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("mismatch at %0t: run hung", $time);
    results();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, aux_busy, aux_release, reg_addr, reg_wdata} = '0;
    input_ready = 6'h00;
    cond = 6'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check({external_function_code, sense_strobe, function_strobe, channel_active}, 0);
    rd(4'h2);
    check(st, 32'h0);
    // sense rows: channel, low bit, condition, position, expected exits
    foreach (rows[r]) begin
      cond <= {6{rows[r][3]}};
      wr(4'h0, {16'h0, rows[r][7:5], 8'h5a, rows[r][4], rows[r][2], 3'h7});
      wait_on(0, 400);
      check(sense_strobe, 6'h01 << (rows[r][7:5] - 3'h1));
      check(external_function_code, {rows[r][7:5], 8'h5a, 1'b0});
      wait_idle();
      check(st[6:5], rows[r][1:0]);
    end
    // lower position half exit repeats the sense
    cond <= 6'h00;
    wr(4'h0, {16'h0, 3'h2, 8'h5a, 1'b0, 1'b0, 3'h7});
    wait_on(0, 400);
    wait_on(1, 1400);
    wait_on(0, 400);
    check(sense_strobe, 6'h02);
    cond <= 6'h3f;
    wait_idle();
    check(st[5], 1'b1);
    // select goes to the named channel and exits full
    wr(4'h0, {16'h0, 3'h3, 8'h5a, 1'b0, 1'b0, 3'h0});
    wait_on(2, 400);
    check(function_strobe, 6'h04);
    wait_idle();
    check(st[5], 1'b1);
    // activation waits for the auxiliary side, then loads the pair
    wr(4'h1, {14'h0, 3'h2, 15'h0123});
    aux_busy <= 1'b1;
    wr(4'h0, {13'h0, 15'h4567, 1'b0, 3'h2});
    repeat (20) @(negedge clk);
    check({storage_busy, channel_active}, 7'h40);
    @(posedge clk);
    aux_busy <= 1'b0;
    wait_on(3, 300);
    check(channel_active, 6'h02);
    rd(4'h3);
    check(st, {2'b0, 15'h4567, 15'h0123});
    check({granted_channel_designator, granted_decode}, {3'h2, 6'h02});
    rd(4'h2);
    check(st[25:10], {3'h2, 1'b1, 6'h02, 6'h02});
    // serve twice: resume then a fresh request on the same channel
    repeat (2) begin
      @(posedge clk);
      aux_release <= 1'b1;
      @(posedge clk);
      aux_release <= 1'b0;
      repeat (2) @(negedge clk);
      check(grant_request, 1'b0);
      wait_on(3, 300);
      check({grant_request, granted_channel_designator}, {1'b1, 3'h2});
    end
    // reset in mid-run clears channel_active, grant_request and storage_busy
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    check({channel_active, grant_request, storage_busy}, 8'h00);
    results();
  end
endmodule
bind buffer_channel_activation channel_checker channel_checker_inst (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .external_function_code, .sense_strobe,
  .function_strobe, .channel_active, .aux_busy, .storage_busy, .grant_request,
  .granted_channel_designator, .granted_decode);
